// >>> hdl/sdw_pkg.sv
// Constants for the serial converter write interface
package sdw_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 8;
  localparam int MODE_BITS = 2;
  localparam int CNT_W = 5;
  // Field positions inside the received word
  localparam int CODE_LSB = 4;
  localparam int MODE_LSB = 12;
  // Reset values and mode encoding
  localparam logic [CODE_BITS-1:0] CODE_RST = 8'h00;
  localparam logic [MODE_BITS-1:0] MODE_RST = 2'h0;
  localparam logic [MODE_BITS-1:0] MODE_NORMAL = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
endpackage

// >>> hdl/sdw_link_if.sv
// Synchronised link signals passed between the converter modules
`timescale 1ns/1ps
interface sdw_link_if;
  logic frame_n;
  logic sclk;
  logic sdata;
  modport src (output frame_n, output sclk, output sdata);
  modport dst (input frame_n, input sclk, input sdata);
endinterface

// >>> hdl/sdw_sync.sv
// Two-stage synchroniser for the three link pins
`timescale 1ns/1ps
module sdw_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic frame_sync_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_data_i,
  sdw_link_if.src link
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;

  // First stage feeds only the second stage; idle frame and clock are high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 3'h6;
      sync_r <= 3'h6;
    end else begin
      meta_r <= {frame_sync_n_i, shift_clk_i, serial_data_i};
      sync_r <= meta_r;
    end
  end

  assign link.frame_n = sync_r[2];
  assign link.sclk = sync_r[1];
  assign link.sdata = sync_r[0];
endmodule // sdw_sync

// >>> hdl/sdw_top.sv
// Serial write interface of an 8-bit voltage-output converter
// Notes on behaviour
// - After frame start, shift data into 16-bit register on falling clocks.
// - Host lowers frame sync to start; shifting only while it stays low.
// - Sixteenth falling edge transfers word and updates converter code.
// - Frame sync rising before sixteenth edge discards word, code unchanged.
// - Reset sets code to zero, held until first complete frame.
// - Converter code is 8 bits; output level proportional to it in normal mode, zero in other modes.
`timescale 1ns/1ps
module sdw_top #(
  parameter int WORD_BITS = sdw_pkg::WORD_BITS
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic frame_sync_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_data_i,
  output logic [sdw_pkg::CODE_BITS-1:0] dac_code_o,
  output logic [sdw_pkg::MODE_BITS-1:0] power_mode_o,
  output logic [sdw_pkg::CODE_BITS-1:0] analog_output_o,
  output logic update_o,
  output logic frame_busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: the word, its fields and the bit counter must agree
  localparam int CODE_END = sdw_pkg::CODE_LSB + sdw_pkg::CODE_BITS;
  localparam int MODE_END = sdw_pkg::MODE_LSB + sdw_pkg::MODE_BITS;
  if (WORD_BITS != sdw_pkg::WORD_BITS) begin : g_bad_word
    $error("sdw_top: WORD_BITS must equal 16");
  end
  // Both fields must lie inside the word and must not overlap
  if (CODE_END > WORD_BITS || MODE_END > WORD_BITS) begin : g_bad_field
    $error("sdw_top: a field runs past the end of the word");
  end
  if (CODE_END > sdw_pkg::MODE_LSB) begin : g_overlap
    $error("sdw_top: code and mode fields overlap");
  end
  // The counter must reach the last bit and one beyond it
  if ((1 << sdw_pkg::CNT_W) <= WORD_BITS) begin : g_bad_count
    $error("sdw_top: bit counter too narrow for the word");
  end
  if (int'(sdw_pkg::CNT_LAST) != WORD_BITS - 1) begin : g_bad_last
    $error("sdw_top: last bit index does not match the word");
  end
  // The synchroniser module is built with a fixed depth of two
  if (sdw_pkg::SYNC_STAGES != 2) begin : g_bad_sync
    $error("sdw_top: synchroniser depth must be two");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame states: waiting for sync, taking bits, word done and frame open
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } sdw_state_t;

  sdw_link_if link ();
  // Registers of the frame path
  sdw_state_t state_r;
  logic sclk_d_r;
  logic frame_d_r;
  logic [WORD_BITS-1:0] shift_r;
  logic [sdw_pkg::CNT_W-1:0] count_r;
  logic [sdw_pkg::CODE_BITS-1:0] code_r;
  logic [sdw_pkg::MODE_BITS-1:0] mode_r;
  logic [sdw_pkg::CODE_BITS-1:0] level_r;
  logic update_r;
  logic busy_r;
  // Decoded events of the synchronised pins
  logic sclk_fall;
  logic frame_fall;
  logic frame_rise;
  logic [WORD_BITS-1:0] word_nxt;
  logic take_bit;
  logic last_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  sdw_sync u_sdw_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .frame_sync_n_i(frame_sync_n_i),
    .shift_clk_i(shift_clk_i),
    .serial_data_i(serial_data_i),
    .link(link.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge history of the synchronised pins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Idle levels: clock parked high, frame closed, so no false edge
      sclk_d_r <= 1'b1;
      frame_d_r <= 1'b1;
    end else begin
      sclk_d_r <= link.sclk;
      frame_d_r <= link.frame_n;
    end
  end

  // Edge detection on synchronised copies only
  assign sclk_fall = sclk_d_r & ~link.sclk;
  assign frame_fall = frame_d_r & ~link.frame_n;
  assign frame_rise = ~frame_d_r & link.frame_n;
  // Most significant bit arrives first, so shift toward the top
  assign word_nxt = {shift_r[WORD_BITS-2:0], link.sdata};
  // A bit is taken on a falling shift clock while the frame stays open;
  // a sync rise in the same cycle wins, so a late edge cannot complete it
  assign take_bit = (state_r == ST_SHIFT) && !frame_rise && sclk_fall;
  // The sixteenth taken bit completes the word
  assign last_bit = take_bit && (count_r == sdw_pkg::CNT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Only a fresh fall of sync opens a frame
          if (frame_fall) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // Sync rising before the last bit ends the frame unloaded
          if (frame_rise) begin
            state_r <= ST_IDLE;
          end else if (sclk_fall && count_r == sdw_pkg::CNT_LAST) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Extra clocks are ignored until the frame closes
          if (link.frame_n) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and bit counter
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_r <= '0;
      count_r <= sdw_pkg::CNT_ZERO;
    end else if (state_r == ST_IDLE) begin
      // Partial words are dropped here
      shift_r <= '0;
      count_r <= sdw_pkg::CNT_ZERO;
    end else if (take_bit) begin
      // Bits enter at the bottom and move toward the top
      shift_r <= word_nxt;
      // Reaches sixteen after the last bit and stays until the frame closes
      count_r <= count_r + sdw_pkg::CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter code, loaded only when a complete word has arrived
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_r <= sdw_pkg::CODE_RST;
    end else if (last_bit) begin
      code_r <= word_nxt[sdw_pkg::CODE_LSB +: sdw_pkg::CODE_BITS];
    end
  end

  // Power mode field of the same word; a short frame leaves it alone
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= sdw_pkg::MODE_RST;
    end else if (last_bit) begin
      mode_r <= word_nxt[sdw_pkg::MODE_LSB +: sdw_pkg::MODE_BITS];
    end
  end

  // One-cycle pulse in the cycle the new code and mode appear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      update_r <= 1'b0;
    end else begin
      update_r <= last_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output level follows code in normal mode, zero when powered down
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_r <= sdw_pkg::CODE_RST;
    end else if (mode_r == sdw_pkg::MODE_NORMAL) begin
      // Normal mode: the level follows the code; other modes hold zero
      level_r <= code_r;
    end else begin
      level_r <= sdw_pkg::CODE_RST;
    end
  end

  // Busy flag for observation of a frame still taking bits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_r == ST_SHIFT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output is taken straight from its register
  assign dac_code_o = code_r;
  assign power_mode_o = mode_r;
  assign analog_output_o = level_r;
  assign update_o = update_r;
  assign frame_busy_o = busy_r;
endmodule // sdw_top

// >>> test/sdw_host_model.sv
// Host model driving serial write frames
`timescale 1ns/1ps
module sdw_host_model (
  input wire logic core_clk_i,
  output logic frame_sync_n_o,
  output logic shift_clk_o,
  output logic serial_data_o
);
  // Idle pins: sync high, clock parked high
  initial begin
    frame_sync_n_o = 1'b1;
    shift_clk_o = 1'b1;
    serial_data_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Send nb bits of w, MSB first, 80 ns shift period
  task automatic send(input logic [15:0] w, input int nb);
    frame_sync_n_o <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    for (int i = 0; i < nb; i++) begin
      shift_clk_o <= 1'b1;
      serial_data_o <= w[15 - (i % 16)];
      repeat (5) @(posedge core_clk_i);
      shift_clk_o <= 1'b0;
      repeat (5) @(posedge core_clk_i);
    end
    shift_clk_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    frame_sync_n_o <= 1'b1;
    serial_data_o <= ~serial_data_o; // Released line shows no old bit
    repeat (6) @(posedge core_clk_i);
  endtask
endmodule // sdw_host_model

// >>> test/sdw_top_sva.sv
// Port checker for the converter write interface
`timescale 1ns/1ps
module sdw_top_chk #(parameter int WORD_BITS = 16) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic frame_sync_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_data_i,
  input wire logic [7:0] dac_code_o,
  input wire logic [1:0] power_mode_o,
  input wire logic [7:0] analog_output_o,
  input wire logic update_o,
  input wire logic frame_busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] busy_cnt_r;
  // Cycles spent with a frame still taking bits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_r <= 8'h00;
    end else if (!frame_busy_o) begin
      busy_cnt_r <= 8'h00;
    end else if (busy_cnt_r != 8'hff) begin
      busy_cnt_r <= busy_cnt_r + 8'h01;
    end
  end
  AST_PULSE: assert property (update_o |=> !update_o)
    else $error("update width");
  AST_CODE_HOLD: assert property (!update_o |-> $stable(dac_code_o))
    else $error("code moved");
  AST_LEVEL: assert property (analog_output_o ==
    (($past(power_mode_o) == 2'h0) ? $past(dac_code_o) : 8'h00))
    else $error("level");
  AST_IN_FRAME: assert property (update_o |-> $past(frame_busy_o))
    else $error("update idle");
  AST_DONE: assert property (update_o |-> ##[0:1] !frame_busy_o)
    else $error("busy stays");
  AST_IDLE: assert property (frame_sync_n_i [*6] |-> !frame_busy_o)
    else $error("busy idle");
  AST_SYNC: assert property (update_o |-> !$past(frame_sync_n_i, 6))
    else $error("update aborted");
  AST_BITS: assert property (update_o |-> busy_cnt_r >= 8'h50)
    else $error("update early");
endmodule // sdw_top_chk
bind sdw_top sdw_top_chk #(.WORD_BITS(WORD_BITS)) u_sdw_top_chk (
  .core_clk_i, .rst_i, .frame_sync_n_i, .shift_clk_i, .serial_data_i,
  .dac_code_o, .power_mode_o, .analog_output_o, .update_o, .frame_busy_o);

// >>> test/test_sdw_top.sv
// Testbench for the converter write interface
`timescale 1ns/1ps
module test_sdw_top;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic frame_sync_n_i, shift_clk_i, serial_data_i, update_o, frame_busy_o;
  logic [7:0] dac_code_o, analog_output_o, exp_code = 8'h00;
  logic [1:0] power_mode_o, exp_mode = 2'h0;
  logic [31:0] seed = 32'h4fb466b3;
  int n_errors = 0, checked = 0, n_upd = 0, cyc = 0;
  always #4 core_clk_i = ~core_clk_i;
  sdw_host_model u_sdw_host_model (.core_clk_i, .frame_sync_n_o(
    frame_sync_n_i), .shift_clk_o(shift_clk_i), .serial_data_o(serial_data_i));
  sdw_top u_sdw_top (.core_clk_i, .rst_i, .frame_sync_n_i, .shift_clk_i,
    .serial_data_i, .dac_code_o, .power_mode_o, .analog_output_o, .update_o,
    .frame_busy_o);
  // Update count and run limit
  always @(posedge core_clk_i) begin
    n_upd += int'(update_o === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Level the output must show for a given mode and code
  function automatic logic [7:0] exp_level(input logic [1:0] m,
                                           input logic [7:0] c);
    return (m == 2'h0) ? c : 8'h00;
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One frame and the outputs it must leave
  task automatic frame(input logic [15:0] w, input int nb);
    int u0;
    u0 = n_upd;
    u_sdw_host_model.send(w, nb);
    if (nb >= 16) begin
      exp_code = w[11:4];
      exp_mode = w[13:12];
    end
    cmp("updates", 8'(nb >= 16), 8'(n_upd - u0));
    cmp("code", exp_code, dac_code_o);
    cmp("mode", {6'h00, exp_mode}, {6'h00, power_mode_o});
    cmp("level", exp_level(exp_mode, exp_code), analog_output_o);
    cmp("busy", 8'h00, {7'h00, frame_busy_o});
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reset, corner frames, then random frames
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    cmp("reset", 8'h00, dac_code_o);
    cmp("reset level", 8'h00, analog_output_o);
    frame(16'h3ff0, 15);
    frame(16'hcff0, 16);
    frame(16'h1a50, 20);
    frame(16'h2000, 16);
    frame(16'h3550, 16);
    frame(16'h0120, 0);
    // Reset in mid-run returns the code to zero until the next full write
    rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    exp_code = 8'h00;
    exp_mode = 2'h0;
    repeat (4) @(posedge core_clk_i);
    cmp("rerun code", 8'h00, dac_code_o);
    cmp("rerun level", 8'h00, analog_output_o);
    frame(16'h0ab0, 9);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      frame(seed[15:0], seed[16] ? int'(seed[20:17]) : 16);
    end
    summarize();
  end
endmodule // test_sdw_top
